// ==== hw/rule_memory_access_engine.v ====
// rule memory access engine: cache, commands, block pool and lookup scan
// assumes a word-addressed avalon-mm master and same-clock lookup requester
//
// Operation
// - one cache holds entry, mask, action and counter of one address
// - wide cache fields split over replicas, low 32 bits first
// - entry bit 0/0 matches only key bit 0
// - entry bit 0/1 matches key bit 0 or 1
// - entry bit 1/0 matches only key bit 1
// - any entry bit 1/1 makes the whole entry match nothing
// - egress instance treats 1/1 as match-any, uses rule enable bit
// - counter increments on match, saturating instead of wrapping
// - code 0 with go copies the cache to the address, go clears
// - code 1 with go loads the address into the cache, go clears
// - code 4 writes the cache to a through a plus distance
// - clear-cache disables entry, zeroes action and counter, before writes
// - three skip flags suppress entry, action or counter in write, read and init; moves ignore them
// - move uses distance, length minus one, code 2 or 3, start a
// - moved-from addresses are left initialized, overlap is safe
// - six blocks of 1024 addresses each, back to back
// - address priority holds across blocks of one owner
// - blocks start unallocated; index then owner code allocates
// - several matches: highest address wins
// - no match: programmable default rule applies
`timescale 1ns/100ps
`include "rule_memory_defines.vh"

module rule_memory_access_engine #(
  parameter ENTRY_W = 36,
  parameter ACTION_W = 70,
  parameter CNT_W = 1,
  parameter NUM_BLOCKS = `NUM_BLOCKS_DFLT,
  parameter BLOCK_SH = `BLOCK_SHIFT_DFLT,
  parameter ADDR_W = 13,
  parameter EGRESS = 0
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // lookup request
  input wire lookup_req,
  input wire [ENTRY_W-1:0] lookup_key,
  input wire [2:0] lookup_owner,
  // lookup answer
  output wire lookup_busy,
  output wire lookup_done,
  output wire lookup_hit,
  output wire [ADDR_W-1:0] lookup_addr,
  output wire [ACTION_W-1:0] lookup_action
);

  localparam D_LO = 0;
  localparam M_LO = ENTRY_W;
  localparam A_LO = 2 * ENTRY_W;
  localparam C_LO = A_LO + ACTION_W;
  localparam E_BIT = C_LO + CNT_W;
  localparam MW = E_BIT + 1;
  localparam DEPTH = (NUM_BLOCKS << BLOCK_SH) + 1;
  // default rule sits just above the pool
  localparam POOL_SZ = NUM_BLOCKS << BLOCK_SH;
  localparam POOL_TOP = POOL_SZ - 1;
  localparam [ADDR_W-1:0] DEF_ADDR = POOL_SZ[ADDR_W-1:0];
  localparam [ADDR_W-1:0] TOP_ADDR = POOL_TOP[ADDR_W-1:0];

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RD = 3'h1;
  localparam [2:0] S_WR = 3'h2;
  localparam [2:0] S_VAC = 3'h3;
  localparam [2:0] S_LK_RD = 3'h4;
  localparam [2:0] S_LK_CHK = 3'h5;

  // disabled entry, zero action and counter
  localparam [MW-1:0] INIT_WORD = {1'b0, {(CNT_W + ACTION_W){1'b0}},
                                   {(2 * ENTRY_W){1'b1}}};

  reg [2:0] state_ff;
  reg [2:0] cmd_ff;
  reg skip_e_ff;
  reg skip_a_ff;
  reg skip_c_ff;
  reg go_ff;
  reg [ADDR_W-1:0] upd_addr_ff;
  reg [15:0] dist_ff;
  reg [15:0] len_ff;
  reg [2:0] blk_sel_ff;
  reg [3*NUM_BLOCKS-1:0] owners_ff;
  reg [ENTRY_W-1:0] cache_data_ff;
  reg [ENTRY_W-1:0] cache_mask_ff;
  reg [ACTION_W-1:0] cache_act_ff;
  reg [CNT_W-1:0] cache_cnt_ff;
  reg cache_ena_ff;
  reg wait_ff;
  reg [31:0] rdata_ff;
  reg [ADDR_W-1:0] op_addr_ff;
  reg [ADDR_W-1:0] mem_addr_ff;
  reg [15:0] cnt_ff;
  reg [MW-1:0] mem [0:DEPTH-1];
  reg [MW-1:0] rd_q_ff;
  reg [ENTRY_W-1:0] lk_key_ff;
  reg [2:0] lk_owner_ff;
  reg lk_busy_ff;
  reg lk_done_ff;
  reg lk_hit_ff;
  reg [ADDR_W-1:0] lk_addr_ff;
  reg [ACTION_W-1:0] lk_act_ff;

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign lookup_busy = lk_busy_ff;
  assign lookup_done = lk_done_ff;
  assign lookup_hit = lk_hit_ff;
  assign lookup_addr = lk_addr_ff;
  assign lookup_action = lk_act_ff;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b])
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  // bus side: a write lands on the edge that ends the low waitrequest cycle
  wire bus_wr = avs_write & ~wait_ff;
  reg [31:0] uc_val;
  reg [31:0] mc_val;
  wire [31:0] uc_new = be_merge(uc_val, avs_writedata, avs_byteenable);
  wire [31:0] mc_new = be_merge(mc_val, avs_writedata, avs_byteenable);
  wire [31:0] bi_new = be_merge({29'h0, blk_sel_ff}, avs_writedata,
                                avs_byteenable);
  // control words are frozen while an operation runs
  wire uc_wr = bus_wr && !go_ff &&
               (avs_address == `REG_UPDATE_CONTROL);
  wire mc_wr = bus_wr && (avs_address == `REG_MOVE_CONFIG) && !go_ff;
  wire bi_wr = bus_wr && (avs_address == `REG_BLOCK_INDEX);
  wire om_wr = bus_wr && (avs_address == `REG_BLOCK_OWNER_MAP);
  wire [2:0] sel_owner = (blk_sel_ff < NUM_BLOCKS) ?
                         owners_ff[blk_sel_ff*3 +: 3] : `OWNER_NONE;
  wire [31:0] om_new = be_merge({29'h0, sel_owner}, avs_writedata,
                                avs_byteenable);

  always @* begin
    uc_val = 32'h00000000;
    uc_val[`UC_CMD_LSB +: 3] = cmd_ff;
    uc_val[`UC_SKIP_ENTRY_BIT] = skip_e_ff;
    uc_val[`UC_SKIP_ACTION_BIT] = skip_a_ff;
    uc_val[`UC_SKIP_COUNTER_BIT] = skip_c_ff;
    uc_val[`UC_GO_BIT] = go_ff;
    uc_val[`UC_ADDR_LSB +: ADDR_W] = upd_addr_ff;
    mc_val = 32'h00000000;
    mc_val[`MC_DIST_LSB +: 16] = dist_ff;
    mc_val[`MC_LEN_LSB +: 16] = len_ff;
  end

  // cache replicas, bits above the field width read as zero
  wire [63:0] data_pad = {{(64 - ENTRY_W){1'b0}}, cache_data_ff};
  wire [63:0] mask_pad = {{(64 - ENTRY_W){1'b0}}, cache_mask_ff};
  wire [95:0] act_pad = {{(96 - ACTION_W){1'b0}}, cache_act_ff};
  wire [31:0] cnt_pad = {{(32 - CNT_W){1'b0}}, cache_cnt_ff};
  wire [31:0] ena_pad = {31'h0, cache_ena_ff};
  reg [63:0] nxt_data_pad;
  reg [63:0] nxt_mask_pad;
  reg [95:0] nxt_act_pad;
  reg [31:0] nxt_cnt_pad;
  reg [31:0] nxt_ena_pad;
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_data_pad = data_pad;
    nxt_mask_pad = mask_pad;
    nxt_act_pad = act_pad;
    nxt_cnt_pad = cnt_pad;
    nxt_ena_pad = ena_pad;
    case (avs_address)
      `REG_ENTRY_DATA0: nxt_data_pad[31:0] =
        be_merge(data_pad[31:0], avs_writedata, avs_byteenable);
      `REG_ENTRY_DATA1: nxt_data_pad[63:32] =
        be_merge(data_pad[63:32], avs_writedata, avs_byteenable);
      `REG_ENTRY_MASK0: nxt_mask_pad[31:0] =
        be_merge(mask_pad[31:0], avs_writedata, avs_byteenable);
      `REG_ENTRY_MASK1: nxt_mask_pad[63:32] =
        be_merge(mask_pad[63:32], avs_writedata, avs_byteenable);
      `REG_ACTION_DATA0: nxt_act_pad[31:0] =
        be_merge(act_pad[31:0], avs_writedata, avs_byteenable);
      `REG_ACTION_DATA1: nxt_act_pad[63:32] =
        be_merge(act_pad[63:32], avs_writedata, avs_byteenable);
      `REG_ACTION_DATA2: nxt_act_pad[95:64] =
        be_merge(act_pad[95:64], avs_writedata, avs_byteenable);
      `REG_COUNTER_DATA: nxt_cnt_pad =
        be_merge(cnt_pad, avs_writedata, avs_byteenable);
      `REG_RULE_ENABLE: nxt_ena_pad =
        be_merge(ena_pad, avs_writedata, avs_byteenable);
      default: ;
    endcase
  end

  always @* begin
    case (avs_address)
      `REG_UPDATE_CONTROL: nxt_rdata = uc_val;
      `REG_MOVE_CONFIG: nxt_rdata = mc_val;
      `REG_BLOCK_INDEX: nxt_rdata = {29'h0, blk_sel_ff};
      `REG_BLOCK_OWNER_MAP: nxt_rdata = {29'h0, sel_owner};
      `REG_ENTRY_DATA0: nxt_rdata = data_pad[31:0];
      `REG_ENTRY_DATA1: nxt_rdata = data_pad[63:32];
      `REG_ENTRY_MASK0: nxt_rdata = mask_pad[31:0];
      `REG_ENTRY_MASK1: nxt_rdata = mask_pad[63:32];
      `REG_ACTION_DATA0: nxt_rdata = act_pad[31:0];
      `REG_ACTION_DATA1: nxt_rdata = act_pad[63:32];
      `REG_ACTION_DATA2: nxt_rdata = act_pad[95:64];
      `REG_COUNTER_DATA: nxt_rdata = cnt_pad;
      `REG_RULE_ENABLE: nxt_rdata = ena_pad;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // match of the word just read against the held key
  wire [ENTRY_W-1:0] rd_data = rd_q_ff[D_LO +: ENTRY_W];
  wire [ENTRY_W-1:0] rd_mask = rd_q_ff[M_LO +: ENTRY_W];
  wire [ENTRY_W-1:0] bit_ok;
  wire [ENTRY_W-1:0] bit_off;
  genvar gi;
  generate
    for (gi = 0; gi < ENTRY_W; gi = gi + 1) begin : g_match
      // mask set is don't-care, else data must equal key
      assign bit_ok[gi] = rd_mask[gi] |
                          (rd_data[gi] ~^ lk_key_ff[gi]);
      assign bit_off[gi] = rd_data[gi] & rd_mask[gi];
    end
  endgenerate
  wire entry_hit = (EGRESS != 0) ? (&bit_ok & rd_q_ff[E_BIT])
                                 : (&bit_ok & ~|bit_off);

  // scan address ownership
  wire [ADDR_W-1:0] blk_num = op_addr_ff >> BLOCK_SH;
  wire [2:0] blk_owner = owners_ff[blk_num*3 +: 3];
  wire is_def = (op_addr_ff == DEF_ADDR);
  wire scan_ok = is_def || (EGRESS != 0) ||
                 ((blk_owner == lk_owner_ff) && (blk_owner != `OWNER_NONE));
  wire lk_sel = entry_hit || is_def;
  wire [CNT_W-1:0] cnt_old = rd_q_ff[C_LO +: CNT_W];
  wire [CNT_W-1:0] cnt_inc = cnt_old + 1'b1;
  wire [CNT_W-1:0] cnt_sat = (&cnt_old) ? cnt_old : cnt_inc;

  // skip flags pick which parts of the cache reach memory
  wire [MW-1:0] cache_word = {cache_ena_ff, cache_cnt_ff, cache_act_ff,
                              cache_mask_ff, cache_data_ff};
  wire [MW-1:0] sel_mask = {~skip_e_ff, {CNT_W{~skip_c_ff}},
                            {ACTION_W{~skip_a_ff}},
                            {(2 * ENTRY_W){~skip_e_ff}}};
  wire [MW-1:0] merged = (cache_word & sel_mask) | (rd_q_ff & ~sel_mask);
  wire is_move = (cmd_ff == `CMD_MOVE_DOWN) || (cmd_ff == `CMD_MOVE_UP);
  // a move refills the whole cache
  wire [MW-1:0] load_mask = is_move ? {MW{1'b1}} : sel_mask;
  wire [MW-1:0] cache_new = (rd_q_ff & load_mask) | (cache_word & ~load_mask);
  wire [ADDR_W-1:0] dist_a = dist_ff[ADDR_W-1:0];
  wire [ADDR_W-1:0] len_a = len_ff[ADDR_W-1:0];
  wire [ADDR_W-1:0] move_dst = (cmd_ff == `CMD_MOVE_DOWN) ?
                               op_addr_ff - dist_a : op_addr_ff + dist_a;
  // upward moves walk from the top so sources are read before overwritten
  wire [ADDR_W-1:0] start_addr = (cmd_ff == `CMD_MOVE_UP) ?
                                 upd_addr_ff + len_a : upd_addr_ff;

  reg mem_we;
  reg [ADDR_W-1:0] mem_wa;
  reg [MW-1:0] mem_wd;
  reg op_done;
  reg cache_load;

  always @* begin
    mem_we = 1'b0;
    mem_wa = op_addr_ff;
    mem_wd = merged;
    op_done = 1'b0;
    cache_load = 1'b0;
    case (state_ff)
      S_WR: begin
        case (cmd_ff)
          `CMD_WRITE: begin
            mem_we = 1'b1;
            op_done = 1'b1;
          end
          `CMD_READ: begin
            cache_load = 1'b1;
            op_done = 1'b1;
          end
          `CMD_INIT: begin
            mem_we = 1'b1;
            op_done = (cnt_ff == dist_ff);
          end
          `CMD_MOVE_DOWN, `CMD_MOVE_UP: begin
            mem_we = 1'b1;
            mem_wa = move_dst;
            mem_wd = rd_q_ff;
            cache_load = 1'b1;
          end
          default: op_done = 1'b1;
        endcase
      end
      S_VAC: begin
        mem_we = 1'b1;
        mem_wd = INIT_WORD;
        op_done = (cnt_ff == len_ff);
      end
      S_LK_CHK: begin
        mem_we = lk_sel;
        mem_wd = rd_q_ff;
        mem_wd[C_LO +: CNT_W] = cnt_sat;
      end
      default: ;
    endcase
  end

  // memory content is not reset, software initializes it
  always @(posedge clk) begin
    rd_q_ff <= mem[mem_addr_ff];
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // register slave and control word
  always @(posedge clk) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      cmd_ff <= `CMD_RST;
      skip_e_ff <= 1'b0;
      skip_a_ff <= 1'b0;
      skip_c_ff <= 1'b0;
      go_ff <= 1'b0;
      upd_addr_ff <= {ADDR_W{1'b0}};
      dist_ff <= `FIELD16_RST;
      len_ff <= `FIELD16_RST;
      blk_sel_ff <= 3'h0;
      owners_ff <= {NUM_BLOCKS{`OWNER_RST}};
    end else begin
      // one wait cycle, then a one-cycle accept with data standing
      if (!wait_ff)
        wait_ff <= 1'b1;
      else if (avs_read || avs_write)
        wait_ff <= 1'b0;
      if (avs_read && wait_ff)
        rdata_ff <= nxt_rdata;
      if (uc_wr) begin
        cmd_ff <= uc_new[`UC_CMD_LSB +: 3];
        skip_e_ff <= uc_new[`UC_SKIP_ENTRY_BIT];
        skip_a_ff <= uc_new[`UC_SKIP_ACTION_BIT];
        skip_c_ff <= uc_new[`UC_SKIP_COUNTER_BIT];
        upd_addr_ff <= uc_new[`UC_ADDR_LSB +: ADDR_W];
        go_ff <= uc_new[`UC_GO_BIT];
      end else if (op_done) begin
        go_ff <= 1'b0;
      end
      if (mc_wr) begin
        dist_ff <= mc_new[`MC_DIST_LSB +: 16];
        len_ff <= mc_new[`MC_LEN_LSB +: 16];
      end
      if (bi_wr)
        blk_sel_ff <= bi_new[2:0];
      // an owned block keeps its owner until reset
      if (om_wr && (blk_sel_ff < NUM_BLOCKS) && (sel_owner == `OWNER_NONE))
        owners_ff[blk_sel_ff*3 +: 3] <= om_new[2:0];
    end
  end

  // cache registers
  always @(posedge clk) begin
    if (sys_rst) begin
      cache_data_ff <= {ENTRY_W{1'b1}};
      cache_mask_ff <= {ENTRY_W{1'b1}};
      cache_act_ff <= {ACTION_W{1'b0}};
      cache_cnt_ff <= {CNT_W{1'b0}};
      cache_ena_ff <= 1'b0;
    end else if (uc_wr && uc_new[`UC_CLEAR_BIT]) begin
      // clear lands before any command of the same write starts
      cache_data_ff <= {ENTRY_W{1'b1}};
      cache_mask_ff <= {ENTRY_W{1'b1}};
      cache_act_ff <= {ACTION_W{1'b0}};
      cache_cnt_ff <= {CNT_W{1'b0}};
      cache_ena_ff <= 1'b0;
    end else if (cache_load) begin
      cache_data_ff <= cache_new[D_LO +: ENTRY_W];
      cache_mask_ff <= cache_new[M_LO +: ENTRY_W];
      cache_act_ff <= cache_new[A_LO +: ACTION_W];
      cache_cnt_ff <= cache_new[C_LO +: CNT_W];
      cache_ena_ff <= cache_new[E_BIT];
    end else if (bus_wr) begin
      cache_data_ff <= nxt_data_pad[ENTRY_W-1:0];
      cache_mask_ff <= nxt_mask_pad[ENTRY_W-1:0];
      cache_act_ff <= nxt_act_pad[ACTION_W-1:0];
      cache_cnt_ff <= nxt_cnt_pad[CNT_W-1:0];
      cache_ena_ff <= nxt_ena_pad[0];
    end
  end

  // operation and lookup sequencer; commands win over a waiting lookup
  always @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= S_IDLE;
      op_addr_ff <= {ADDR_W{1'b0}};
      mem_addr_ff <= {ADDR_W{1'b0}};
      cnt_ff <= 16'h0000;
      lk_key_ff <= {ENTRY_W{1'b0}};
      lk_owner_ff <= `OWNER_NONE;
      lk_busy_ff <= 1'b0;
      lk_done_ff <= 1'b0;
      lk_hit_ff <= 1'b0;
      lk_addr_ff <= {ADDR_W{1'b0}};
      lk_act_ff <= {ACTION_W{1'b0}};
    end else begin
      lk_done_ff <= 1'b0;
      if (lookup_req && !lk_busy_ff) begin
        lk_busy_ff <= 1'b1;
        lk_key_ff <= lookup_key;
        lk_owner_ff <= lookup_owner;
      end
      case (state_ff)
        S_IDLE: begin
          if (go_ff) begin
            cnt_ff <= 16'h0000;
            op_addr_ff <= start_addr;
            mem_addr_ff <= start_addr;
            state_ff <= S_RD;
          end else if (lk_busy_ff) begin
            // scan downward so the highest matching address wins
            op_addr_ff <= TOP_ADDR;
            mem_addr_ff <= TOP_ADDR;
            state_ff <= S_LK_RD;
          end
        end
        S_RD: state_ff <= S_WR;
        S_WR: begin
          if (is_move) begin
            state_ff <= S_VAC;
          end else if (op_done) begin
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            op_addr_ff <= op_addr_ff + 1'b1;
            mem_addr_ff <= op_addr_ff + 1'b1;
            state_ff <= S_RD;
          end
        end
        S_VAC: begin
          if (op_done) begin
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            if (cmd_ff == `CMD_MOVE_DOWN) begin
              op_addr_ff <= op_addr_ff + 1'b1;
              mem_addr_ff <= op_addr_ff + 1'b1;
            end else begin
              op_addr_ff <= op_addr_ff - 1'b1;
              mem_addr_ff <= op_addr_ff - 1'b1;
            end
            state_ff <= S_RD;
          end
        end
        S_LK_RD: begin
          if (scan_ok) begin
            state_ff <= S_LK_CHK;
          end else if (op_addr_ff == {ADDR_W{1'b0}}) begin
            op_addr_ff <= DEF_ADDR;
            mem_addr_ff <= DEF_ADDR;
          end else begin
            op_addr_ff <= op_addr_ff - 1'b1;
            mem_addr_ff <= op_addr_ff - 1'b1;
          end
        end
        S_LK_CHK: begin
          if (lk_sel) begin
            lk_done_ff <= 1'b1;
            lk_hit_ff <= ~is_def;
            lk_addr_ff <= op_addr_ff;
            lk_act_ff <= rd_q_ff[A_LO +: ACTION_W];
            lk_busy_ff <= 1'b0;
            state_ff <= S_IDLE;
          end else begin
            if (op_addr_ff == {ADDR_W{1'b0}}) begin
              op_addr_ff <= DEF_ADDR;
              mem_addr_ff <= DEF_ADDR;
            end else begin
              op_addr_ff <= op_addr_ff - 1'b1;
              mem_addr_ff <= op_addr_ff - 1'b1;
            end
            state_ff <= S_LK_RD;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

endmodule // rule_memory_access_engine

// ==== inc/rule_memory_defines.vh ====
// constants shared by the rule memory access engine
// assumes word addressing on the register slave, one 32-bit word per index
`ifndef RULE_MEMORY_DEFINES_VH
`define RULE_MEMORY_DEFINES_VH

// register word indices
`define REG_UPDATE_CONTROL 4'h0
`define REG_MOVE_CONFIG 4'h1
`define REG_BLOCK_INDEX 4'h2
`define REG_BLOCK_OWNER_MAP 4'h3
`define REG_ENTRY_DATA0 4'h4
`define REG_ENTRY_DATA1 4'h5
`define REG_ENTRY_MASK0 4'h6
`define REG_ENTRY_MASK1 4'h7
`define REG_ACTION_DATA0 4'h8
`define REG_ACTION_DATA1 4'h9
`define REG_ACTION_DATA2 4'hA
`define REG_COUNTER_DATA 4'hB
`define REG_RULE_ENABLE 4'hC

// update_control fields
`define UC_CMD_LSB 0
`define UC_SKIP_ENTRY_BIT 3
`define UC_SKIP_ACTION_BIT 4
`define UC_SKIP_COUNTER_BIT 5
`define UC_CLEAR_BIT 6
`define UC_GO_BIT 7
`define UC_ADDR_LSB 16

// move_config fields
`define MC_DIST_LSB 0
`define MC_LEN_LSB 16

// operation codes
`define CMD_WRITE 3'h0
`define CMD_READ 3'h1
`define CMD_MOVE_DOWN 3'h2
`define CMD_MOVE_UP 3'h3
`define CMD_INIT 3'h4

// block owner codes
`define OWNER_NONE 3'h0
`define OWNER_CLASSIFY 3'h1
`define OWNER_INGRESS2 3'h2
`define OWNER_PREFIX 3'h3

// reset values
`define CMD_RST 3'h0
`define FIELD16_RST 16'h0000
`define OWNER_RST 3'h0

// pool geometry
`define NUM_BLOCKS_DFLT 6
`define BLOCK_SHIFT_DFLT 10

`endif

// ==== tb/rule_memory_access_engine_properties.sv ====
// port checker for the rule memory access engine
// assumes one clock and the synchronous sys_rst of the engine
`timescale 1ns/100ps
module rule_memory_access_engine_chk #(
  parameter NUM_BLOCKS = 6,
  parameter BLOCK_SH = 10,
  parameter ADDR_W = 13
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register slave
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // lookup
  input wire lookup_req,
  input wire lookup_busy,
  input wire lookup_done,
  input wire lookup_hit,
  input wire [ADDR_W-1:0] lookup_addr
);
  localparam [ADDR_W-1:0] DFLT = NUM_BLOCKS << BLOCK_SH;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_accept;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_accept: assert property (p_accept)
    else $error("no accept");
  property p_one_wait;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("long accept");
  property p_no_spur;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("spurious");
  property p_start;
    lookup_req && !lookup_busy |=> lookup_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("lookup not taken");
  property p_bounded;
    $rose(lookup_busy) |-> ##[1:400] lookup_done;
  endproperty
  a_bounded: assert property (p_bounded)
    else $error("lookup hang");
  property p_end;
    $fell(lookup_busy) |-> lookup_done ##1 !lookup_done;
  endproperty
  a_end: assert property (p_end)
    else $error("done framing");
  property p_default;
    lookup_done && !lookup_hit |-> lookup_addr == DFLT;
  endproperty
  a_default: assert property (p_default)
    else $error("default addr");
  property p_pool;
    lookup_done && lookup_hit |-> lookup_addr < DFLT;
  endproperty
  a_pool: assert property (p_pool)
    else $error("hit outside pool");
  property p_hold;
    !lookup_done |-> $stable(lookup_addr) && $stable(lookup_hit);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer moved");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_hit: cover property (lookup_done && lookup_hit);
  c_miss: cover property (lookup_done && !lookup_hit);
endmodule // rule_memory_access_engine_chk

bind rule_memory_access_engine rule_memory_access_engine_chk #(
  .NUM_BLOCKS(NUM_BLOCKS), .BLOCK_SH(BLOCK_SH), .ADDR_W(ADDR_W)
) u_chk (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .lookup_req(lookup_req), .lookup_busy(lookup_busy),
  .lookup_done(lookup_done), .lookup_hit(lookup_hit),
  .lookup_addr(lookup_addr));

// ==== tb/tb_top.sv ====
// self-checking bench for the rule memory access engine
// assumes a shrunk pool of 16-address blocks, so default rule sits at 96
`timescale 1ns/100ps
`include "rule_memory_defines.vh"
module tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  reg lookup_req = 1'b0;
  reg [35:0] lookup_key = 36'h0;
  reg [2:0] lookup_owner = 3'h1;
  wire lookup_busy;
  wire lookup_done;
  wire lookup_hit;
  wire [6:0] lookup_addr;
  wire [69:0] lookup_action;
  integer n_errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  reg [31:0] rd;
  always #20 clk = ~clk;
  rule_memory_access_engine #(.NUM_BLOCKS(6), .BLOCK_SH(4), .ADDR_W(7))
  u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lookup_req(lookup_req), .lookup_key(lookup_key),
    .lookup_owner(lookup_owner), .lookup_busy(lookup_busy),
    .lookup_done(lookup_done), .lookup_hit(lookup_hit),
    .lookup_addr(lookup_addr), .lookup_action(lookup_action));
  task test_done;
    begin
      if (n_errors == 0 && comparisons > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // scans are short with the shrunk pool; a hang ends here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task bus(input [3:0] a, input wr, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task rchk(input [3:0] a, input string nm, input [31:0] exp);
    begin
      bus(a, 1'b0, 32'h0);
      chk(nm, exp, rd);
    end
  endtask
  // go is polled, never waited for by a fixed count
  task cmd(input [6:0] a, input [7:0] f);
    integer i;
    begin
      bus(4'h0, 1'b1, {9'h0, a, 8'h0, f | 8'h80});
      rd = 32'h80;
      // no cache access or new command while go still reads one
      for (i = 0; i < 200 && rd[7]; i = i + 1)
        bus(4'h0, 1'b0, 32'h0);
      chk("go", 32'h0, rd & 32'h80);
    end
  endtask
  task look(input [35:0] k, input h, input [6:0] a, input [31:0] act);
    begin
      @(posedge clk);
      lookup_key <= k;
      lookup_req <= 1'b1;
      @(posedge clk);
      lookup_req <= 1'b0;
      @(posedge clk);
      while (!lookup_done) @(posedge clk);
      chk("hit", {31'h0, h}, {31'h0, lookup_hit});
      chk("addr", {25'h0, a}, {25'h0, lookup_addr});
      chk("action", act, lookup_action[31:0]);
    end
  endtask
  task t_reset;
    begin
      rchk(4'h4, "ent0", 32'hFFFFFFFF);
      rchk(4'h5, "ent1", 32'h0000000F);
      bus(4'hA, 1'b1, 32'hFFFFFFFF);
      rchk(4'hA, "act2", 32'h0000003F);
      rchk(4'h3, "owner", 32'h0);
      rchk(4'hD, "unmapped", 32'h0);
    end
  endtask
  // allocation is done once, before any lookup
  task t_alloc;
    begin
      bus(4'h2, 1'b1, 32'h2);
      bus(4'h3, 1'b1, 32'h1);
      bus(4'h3, 1'b1, 32'h2);
      rchk(4'h3, "owner", 32'h1);
    end
  endtask
  task t_rule;
    begin
      bus(4'h1, 1'b1, 32'h60);
      cmd(7'd0, 8'h40 | {5'h0, `CMD_INIT});
      look(36'hA5, 1'b0, 7'd96, 32'h0);
      bus(4'h4, 1'b1, 32'h5);
      bus(4'h5, 1'b1, 32'h0);
      bus(4'h6, 1'b1, 32'hF0);
      bus(4'h7, 1'b1, 32'h0);
      bus(4'h8, 1'b1, 32'h1234);
      cmd(7'd35, {5'h0, `CMD_WRITE});
      cmd(7'd40, {5'h0, `CMD_WRITE});
      bus(4'h5, 1'b1, 32'h8);
      bus(4'h7, 1'b1, 32'h8);
      bus(4'h8, 1'b1, 32'hBAD);
      cmd(7'd44, {5'h0, `CMD_WRITE});
      look(36'hA5, 1'b1, 7'd40, 32'h1234);
      look(36'h07, 1'b0, 7'd96, 32'h0);
      look(36'hA4, 1'b0, 7'd96, 32'h0);
      look(36'h35, 1'b1, 7'd40, 32'h1234);
    end
  endtask
  task t_count;
    begin
      bus(4'h0, 1'b1, 32'h40);
      rchk(4'h8, "act0", 32'h0);
      cmd(7'd40, {5'h0, `CMD_READ});
      rchk(4'h8, "act0", 32'h1234);
      rchk(4'hB, "count", 32'h1);
      cmd(7'd40, 8'h58 | {5'h0, `CMD_WRITE});
      cmd(7'd40, {5'h0, `CMD_READ});
      rchk(4'h8, "act0", 32'h1234);
      rchk(4'hB, "count", 32'h0);
    end
  endtask
  task t_move;
    begin
      bus(4'h1, 1'b1, 32'h2);
      cmd(7'd40, {5'h0, `CMD_MOVE_UP});
      look(36'hA5, 1'b1, 7'd42, 32'h1234);
      bus(4'h1, 1'b1, 32'h1);
      cmd(7'd42, {5'h0, `CMD_MOVE_DOWN});
      look(36'hA5, 1'b1, 7'd41, 32'h1234);
      cmd(7'd42, {5'h0, `CMD_READ});
      rchk(4'h4, "ent0", 32'hFFFFFFFF);
      // another owner must not see the block owned by the first
      lookup_owner <= 3'h2;
      look(36'hA5, 1'b0, 7'd96, 32'h0);
      lookup_owner <= 3'h1;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_alloc;
    t_rule;
    t_count;
    t_move;
    test_done;
  end
endmodule // tb_top
